// ---- design/sst_map.vh ----
// register offsets, field positions and constants of the synchronous transmit block
// assumes a plain address/strobe register port with 4-bit addresses
`ifndef SST_MAP_VH
`define SST_MAP_VH

`define SST_ADDR_W         4
`define SST_OFS_TXCTL      4'h0
`define SST_OFS_RXCTL      4'h1
`define SST_OFS_HOLD       4'h2
`define SST_OFS_STATUS     4'h3
`define SST_OFS_MASK       4'h4
`define SST_OFS_BAUDL      4'h5
`define SST_OFS_BAUDH      4'h6
`define SST_OFS_SYSCTL     4'h7

// transmit status/control fields
`define SST_TX_NINTH       0
`define SST_TX_BUFEMPTY    1
`define SST_TX_SHIFTEMPTY  2
`define SST_TX_HIGHSPEED   3
`define SST_TX_SYNC        4
`define SST_TX_EN          5
`define SST_TX_NINE        6
`define SST_TX_CLKMASTER   7

// receive status/control fields
`define SST_RX_CONT        4
`define SST_RX_SINGLE      5
`define SST_RX_PORTEN      7

// system control fields
`define SST_SYS_GIE        0
`define SST_SYS_PEIE       1
`define SST_SYS_SLEEP      2
`define SST_SYS_WIDEBAUD   3

// sticky status / mask fields
`define SST_EV_BUFEMPTY    0
`define SST_EV_DONE        1
`define SST_EV_W           2

`define SST_TXCTL_RESET    8'h02
`define SST_ZERO8          8'h00
`define SST_ZERO16         16'h0000
`define SST_ONE16          16'h0001
`define SST_CNT_W          4
`define SST_CNT_ZERO       4'h0
`define SST_CNT_ONE        4'h1
`define SST_BITS8          4'h8
`define SST_BITS9          4'h9
`define SST_HALF_PRE_LO    16'h0001
`define SST_SYNC_W         3

`endif

// ---- design/sst_edge_sync.v ----
// three-stage synchroniser for an outside level, with change accepted when stages two and three agree
// assumes the input is asynchronous to mclk; rise and fall are one-cycle pulses
`timescale 1ns/1ns
`default_nettype none
`include "sst_map.vh"

module sst_edge_sync (
  // clock and reset
  input  wire mclk,
  input  wire reset,
  // level in and out
  input  wire din,
  output reg  level_reg,
  output reg  rise_reg,
  output reg  fall_reg
);

  reg [`SST_SYNC_W-1:0] stage_reg;

  always @(posedge mclk) begin
    if (reset) begin
      // the clock pin idles high, so start there and no false edge follows reset
      stage_reg <= {`SST_SYNC_W{1'b1}};
      level_reg <= 1'b1;
      rise_reg  <= 1'b0;
      fall_reg  <= 1'b0;
    end else begin
      stage_reg <= {stage_reg[1:0], din};
      rise_reg  <= 1'b0;
      fall_reg  <= 1'b0;
      // stage 0 is only ever read by stage 1
      if (stage_reg[1] == stage_reg[2] && stage_reg[2] != level_reg) begin
        level_reg <= stage_reg[2];
        rise_reg  <= stage_reg[2];
        fall_reg  <= ~stage_reg[2];
      end
    end
  end

endmodule

`default_nettype wire

// ---- design/sst_transmit.v ----
// synchronous transmit path of the enhanced serial port: registers, master/slave shifter, interrupt
// assumes a single-cycle register port; the slave clock pin is asynchronous and sampled by mclk
`timescale 1ns/1ns
`default_nettype none
`include "sst_map.vh"

module sst_transmit (
  // clock and reset
  input  wire                   mclk,
  input  wire                   reset,
  // register port
  input  wire [`SST_ADDR_W-1:0] reg_addr,
  input  wire [7:0]             reg_wdata,
  input  wire                   reg_wr,
  input  wire                   reg_rd,
  output reg  [7:0]             reg_rdata,
  // serial data pin
  input  wire                   serial_data_pin_in,
  output reg                    serial_data_pin_out,
  output reg                    serial_data_pin_oe,
  // serial clock pin
  input  wire                   serial_clock_pin_in,
  output reg                    serial_clock_pin_out,
  output reg                    serial_clock_pin_oe,
  // interrupt and power
  output reg                    irq,
  output reg                    wake,
  output reg                    vector_req
);

  localparam ST_IDLE  = 2'h0;
  localparam ST_LOAD  = 2'h1;
  localparam ST_SHIFT = 2'h2;
  localparam ST_TAIL  = 2'h3;

  reg [7:0]  transmit_status_control_reg;
  reg [7:0]  receive_status_control_reg;
  reg [7:0]  transmit_holding_register_reg;
  reg        hold_ninth_reg;
  reg        hold_full_reg;
  reg [7:0]  baud_divisor_low_reg;
  reg [7:0]  baud_divisor_high_reg;
  reg [7:0]  sysctl_reg;
  reg [`SST_EV_W-1:0] event_reg;
  reg [`SST_EV_W-1:0] mask_reg;
  reg [8:0]  transmit_shift_register_reg;
  reg [`SST_CNT_W-1:0] bits_left_reg;
  reg [1:0]  state_reg;
  reg [15:0] baud_cnt_reg;
  reg        clk_level_reg;

  wire       slave_clk_rise;
  wire       slave_clk_fall;

  sst_edge_sync u_clk_sync (
    .mclk      (mclk),
    .reset     (reset),
    .din       (serial_clock_pin_in),
    .level_reg (),
    .rise_reg  (slave_clk_rise),
    .fall_reg  (slave_clk_fall)
  );

  function is_addr;
    input [`SST_ADDR_W-1:0] a;
    input [`SST_ADDR_W-1:0] ofs;
    begin
      is_addr = (a == ofs);
    end
  endfunction

  // shift edges per character: eight, or nine with the ninth bit last
  function [`SST_CNT_W-1:0] char_bits;
    input nine;
    begin
      char_bits = nine ? `SST_BITS9 : `SST_BITS8;
    end
  endfunction

  wire sync_mode     = transmit_status_control_reg[`SST_TX_SYNC];
  wire clk_master    = transmit_status_control_reg[`SST_TX_CLKMASTER];
  wire rx_selected   = receive_status_control_reg[`SST_RX_SINGLE] |
                       receive_status_control_reg[`SST_RX_CONT];
  wire port_on       = receive_status_control_reg[`SST_RX_PORTEN];
  // port enabled, clocked mode and both receive enables clear: transmit configuration
  wire tx_cfg        = port_on & sync_mode & ~rx_selected;
  wire tx_on         = tx_cfg & transmit_status_control_reg[`SST_TX_EN];
  wire sleeping      = sysctl_reg[`SST_SYS_SLEEP];
  wire wide_baud     = sysctl_reg[`SST_SYS_WIDEBAUD];
  wire nine_bits     = transmit_status_control_reg[`SST_TX_NINE];

  // master divisor: wide generator uses both bytes, otherwise the low byte only
  wire [15:0] divisor = wide_baud ? {baud_divisor_high_reg, baud_divisor_low_reg}
                                  : {`SST_ZERO8, baud_divisor_low_reg};
  wire master_tick   = (baud_cnt_reg == `SST_ZERO16);
  // the master's own shift edge mirrors the falling edge seen on the pin in slave mode
  wire shift_edge    = clk_master ? (master_tick & clk_level_reg) : slave_clk_fall;
  wire hold_write    = reg_wr & is_addr(reg_addr, `SST_OFS_HOLD);
  wire status_read   = reg_rd & is_addr(reg_addr, `SST_OFS_STATUS);
  // per-register write strobes
  wire wr_txctl      = reg_wr & is_addr(reg_addr, `SST_OFS_TXCTL);
  wire wr_rxctl      = reg_wr & is_addr(reg_addr, `SST_OFS_RXCTL);
  wire wr_baudl      = reg_wr & is_addr(reg_addr, `SST_OFS_BAUDL);
  wire wr_baudh      = reg_wr & is_addr(reg_addr, `SST_OFS_BAUDH);
  wire wr_mask       = reg_wr & is_addr(reg_addr, `SST_OFS_MASK);
  wire wr_sysctl     = reg_wr & is_addr(reg_addr, `SST_OFS_SYSCTL);
  wire shift_idle    = (state_reg == ST_IDLE);
  wire load_now      = tx_on & hold_full_reg & shift_idle;
  wire last_bit      = (state_reg == ST_SHIFT) & shift_edge & (bits_left_reg == `SST_CNT_ONE);
  // a character ends only when its last clock period is over, so no low phase is cut short
  wire tail_done     = clk_master ? (master_tick & ~clk_level_reg) : slave_clk_rise;

  // buffer-empty event: the moment a word leaves the holding register
  wire ev_bufempty   = load_now;
  wire ev_done       = last_bit;
  wire [`SST_EV_W-1:0] ev_set;
  assign ev_set[`SST_EV_BUFEMPTY] = ev_bufempty;
  assign ev_set[`SST_EV_DONE]     = ev_done;

  // registers written by software
  always @(posedge mclk) begin
    if (reset) begin
      transmit_status_control_reg <= `SST_TXCTL_RESET;
      receive_status_control_reg  <= `SST_ZERO8;
      baud_divisor_low_reg        <= `SST_ZERO8;
      baud_divisor_high_reg       <= `SST_ZERO8;
      sysctl_reg                  <= `SST_ZERO8;
      mask_reg                    <= {`SST_EV_W{1'b0}};
    end else begin
      if (wr_txctl) begin
        // the two empty flags are hardware state and ignore writes
        transmit_status_control_reg[7:3] <= reg_wdata[7:3];
        transmit_status_control_reg[`SST_TX_NINTH] <= reg_wdata[`SST_TX_NINTH];
      end
      transmit_status_control_reg[`SST_TX_BUFEMPTY]   <= ~hold_full_reg | load_now;
      transmit_status_control_reg[`SST_TX_SHIFTEMPTY] <= shift_idle & ~load_now;
      if (wr_rxctl) begin
        receive_status_control_reg <= reg_wdata;
      end
      if (wr_baudl) begin
        baud_divisor_low_reg <= reg_wdata;
      end
      if (wr_baudh) begin
        baud_divisor_high_reg <= reg_wdata;
      end
      if (wr_mask) begin
        mask_reg <= reg_wdata[`SST_EV_W-1:0];
      end
      // a software write wins over the hardware clear of the sleep bit
      if (wr_sysctl) begin
        sysctl_reg <= reg_wdata;
      end else if (sleeping && irq && sysctl_reg[`SST_SYS_PEIE]) begin
        sysctl_reg[`SST_SYS_SLEEP] <= 1'b0;
      end
    end
  end

  // holding register: one word waits while the shifter is busy, also in sleep
  // a write while a word already waits replaces it; software polls the empty flag first
  always @(posedge mclk) begin
    if (reset) begin
      transmit_holding_register_reg <= `SST_ZERO8;
      hold_ninth_reg                <= 1'b0;
      hold_full_reg                 <= 1'b0;
    end else begin
      if (hold_write) begin
        transmit_holding_register_reg <= reg_wdata;
        hold_ninth_reg                <= transmit_status_control_reg[`SST_TX_NINTH];
        hold_full_reg                 <= 1'b1;
      end else if (load_now) begin
        hold_full_reg <= 1'b0;
      end
    end
  end

  // shifter, LSB first, eight or nine bits
  always @(posedge mclk) begin
    if (reset) begin
      state_reg                   <= ST_IDLE;
      transmit_shift_register_reg <= 9'h000;
      bits_left_reg               <= `SST_CNT_ZERO;
    end else if (!tx_on) begin
      state_reg     <= ST_IDLE;
      bits_left_reg <= `SST_CNT_ZERO;
    end else begin
      case (state_reg)
        ST_IDLE: begin
          if (load_now) begin
            transmit_shift_register_reg <= {hold_ninth_reg, transmit_holding_register_reg};
            bits_left_reg <= char_bits(nine_bits);
            state_reg     <= ST_LOAD;
          end
        end
        ST_LOAD: begin
          state_reg <= ST_SHIFT;
        end
        ST_SHIFT: begin
          if (shift_edge) begin
            transmit_shift_register_reg <= {1'b0, transmit_shift_register_reg[8:1]};
            bits_left_reg <= bits_left_reg - `SST_CNT_ONE;
            if (bits_left_reg == `SST_CNT_ONE)
              state_reg <= ST_TAIL;
          end
        end
        // the next word waits here until the clock has returned high
        ST_TAIL: begin
          if (tail_done)
            state_reg <= ST_IDLE;
        end
        default: begin
          state_reg <= ST_IDLE;
        end
      endcase
    end
  end

  // master clock generator; idles high, runs only in the shift and tail states
  always @(posedge mclk) begin
    if (reset) begin
      baud_cnt_reg  <= `SST_ZERO16;
      clk_level_reg <= 1'b1;
    end else if (!(tx_on && clk_master && (state_reg == ST_SHIFT || state_reg == ST_TAIL))) begin
      baud_cnt_reg  <= divisor;
      clk_level_reg <= 1'b1;
    end else if (master_tick) begin
      baud_cnt_reg  <= divisor;
      clk_level_reg <= ~clk_level_reg;
    end else begin
      baud_cnt_reg  <= baud_cnt_reg - `SST_ONE16;
    end
  end

  // pins
  always @(posedge mclk) begin
    if (reset) begin
      serial_data_pin_out  <= 1'b0;
      serial_data_pin_oe   <= 1'b0;
      serial_clock_pin_out <= 1'b1;
      serial_clock_pin_oe  <= 1'b0;
    end else begin
      serial_data_pin_oe   <= tx_cfg;
      serial_data_pin_out  <= transmit_shift_register_reg[0];
      serial_clock_pin_oe  <= port_on & sync_mode & clk_master;
      serial_clock_pin_out <= clk_level_reg;
    end
  end

  // sticky events, cleared by a status read; a new event wins over the clear
  // wake and the hardware sleep clear fall on one edge, so wake is a single-cycle pulse unless a software write sets sleep on that edge
  always @(posedge mclk) begin
    if (reset) begin
      event_reg  <= {`SST_EV_W{1'b0}};
      irq        <= 1'b0;
      wake       <= 1'b0;
      vector_req <= 1'b0;
    end else begin
      event_reg  <= (status_read ? {`SST_EV_W{1'b0}} : event_reg) | ev_set;
      irq        <= |(event_reg & mask_reg);
      wake       <= sleeping & irq & sysctl_reg[`SST_SYS_PEIE];
      vector_req <= irq & sysctl_reg[`SST_SYS_PEIE] & sysctl_reg[`SST_SYS_GIE];
    end
  end

  // read data one cycle after the strobe; unmapped reads return zero
  always @(posedge mclk) begin
    if (reset) begin
      reg_rdata <= `SST_ZERO8;
    end else if (reg_rd) begin
      case (reg_addr)
        `SST_OFS_TXCTL:  reg_rdata <= transmit_status_control_reg;
        `SST_OFS_RXCTL:  reg_rdata <= receive_status_control_reg;
        `SST_OFS_HOLD:   reg_rdata <= transmit_holding_register_reg;
        `SST_OFS_STATUS: reg_rdata <= {6'h00, event_reg};
        `SST_OFS_MASK:   reg_rdata <= {6'h00, mask_reg};
        `SST_OFS_BAUDL:  reg_rdata <= baud_divisor_low_reg;
        `SST_OFS_BAUDH:  reg_rdata <= baud_divisor_high_reg;
        `SST_OFS_SYSCTL: reg_rdata <= sysctl_reg;
        default:         reg_rdata <= `SST_ZERO8;
      endcase
    end else begin
      reg_rdata <= `SST_ZERO8;
    end
  end

endmodule

`default_nettype wire

// ---- verif/sst_transmit_assertions.sv ----
// port checker for the synchronous transmit block
// assumes the bench sets a divisor of 3, so a master clock low phase is 4 cycles
`timescale 1ns/1ns
`default_nettype none
module sst_transmit_assertions (
  // clock and reset
  input wire logic       mclk,
  input wire logic       reset,
  // register port
  input wire logic [3:0] reg_addr,
  input wire logic       reg_rd,
  input wire logic       reg_wr,
  input wire logic [7:0] reg_rdata,
  // pins and interrupt
  input wire logic       serial_data_pin_oe,
  input wire logic       serial_clock_pin_out,
  input wire logic       serial_clock_pin_oe,
  input wire logic       irq,
  input wire logic       wake,
  input wire logic       vector_req
);
  default clocking @(posedge mclk); endclocking
  default disable iff (reset);
  rdata_idle_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
    else $error("read data outside its cycle");
  unmapped_read_a: assert property ($past(reg_rd && reg_addr > 4'h7) |-> reg_rdata == 8'h00)
    else $error("unmapped read not zero");
  clk_low_a: assert property ($fell(serial_clock_pin_out) |-> (!serial_clock_pin_out)[*4] ##1 serial_clock_pin_out)
    else $error("master clock low phase wrong");
  clk_fall_oe_a: assert property ($fell(serial_clock_pin_out) |-> serial_clock_pin_oe)
    else $error("clock driven while not master");
  data_oe_cause_a: assert property ($changed(serial_data_pin_oe) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
    else $error("data enable moved without a write");
  clk_oe_cause_a: assert property ($changed(serial_clock_pin_oe) |-> $past(reg_wr) || $past(reg_wr, 2) || $past(reg_wr, 3))
    else $error("clock enable moved without a write");
  vector_irq_a: assert property (vector_req |-> irq || $past(irq))
    else $error("vector without interrupt");
  wake_irq_a: assert property (wake |-> irq || $past(irq))
    else $error("wake without interrupt");
  cover property (vector_req);
  cover property (wake);
  cover property ($fell(serial_clock_pin_out));
endmodule
`default_nettype wire

// ---- verif/sst_ext_peer.sv ----
// far side model: clock master for slave transmit, bit catcher in both modes
// assumes the bench resolves the shared lines
`timescale 1ns/1ns
`default_nettype none
module sst_ext_peer (
  // shared lines as seen on the wire
  input  wire logic clk_line,
  input  wire logic data_line,
  // clock driven while the port is a slave
  output logic      clk_drive
);
  logic [8:0] rx;
  logic [3:0] cnt;
  // delayed copy keeps the sample clear of a data change on the same edge
  wire d_dly;
  assign #5 d_dly = data_line;
  initial clk_drive = 1'b1;
  // least significant bit first, so each bit enters at the top
  always @(negedge clk_line) begin
    rx <= {d_dly, rx[8:1]};
    cnt <= cnt + 4'h1;
  end
  // one 160 ns period per bit, clock stands high between frames
  task frame(input int n);
    #7;
    repeat (n) begin
      #80 clk_drive = 1'b0;
      #80 clk_drive = 1'b1;
    end
  endtask
endmodule
`default_nettype wire

// ---- verif/sst_transmit_tb_top.sv ----
// top bench for the synchronous transmit block
// assumes the peer model and checker are compiled first
`timescale 1ns/1ns
`default_nettype none
`include "sst_map.vh"
module sst_transmit_tb_top;
  logic       mclk = 1'b0;
  logic       reset = 1'b1;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h00;
  logic       reg_wr = 1'b0;
  logic       reg_rd = 1'b0;
  logic [7:0] reg_rdata;
  logic [7:0] rv;
  logic       serial_data_pin_out, serial_data_pin_oe, serial_clock_pin_out, serial_clock_pin_oe;
  logic       irq, wake, vector_req, peer_clk;
  int         num_errors = 0;
  int         samples_checked = 0;
  // released data line has a pull-up; a released clock comes from the peer
  wire serial_clock_pin_in = serial_clock_pin_oe ? serial_clock_pin_out : peer_clk;
  wire serial_data_pin_in = serial_data_pin_oe ? serial_data_pin_out : 1'b1;
  always #10 mclk = ~mclk;
  sst_transmit uut (.mclk, .reset, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata,
    .serial_data_pin_in, .serial_data_pin_out, .serial_data_pin_oe, .serial_clock_pin_in,
    .serial_clock_pin_out, .serial_clock_pin_oe, .irq, .wake, .vector_req);
  sst_ext_peer pr (.clk_line(serial_clock_pin_in), .data_line(serial_data_pin_in), .clk_drive(peer_clk));
  task chk(input logic [8:0] got, input logic [8:0] exp);
    samples_checked++;
    if (got !== exp) begin
      num_errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, got, exp);
    end
  endtask
  task wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge mclk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'b1;
    @(posedge mclk);
    reg_wr <= 1'b0;
  endtask
  task rd(input logic [3:0] a);
    @(posedge mclk);
    reg_addr <= a;
    reg_rd <= 1'b1;
    @(posedge mclk);
    reg_rd <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task rdchk(input logic [3:0] a, input logic [7:0] e);
    rd(a);
    chk({1'b0, rv}, {1'b0, e});
  endtask
  task settle;
    repeat (2) @(posedge mclk);
    #1;
  endtask
  task oechk(input logic [3:0] a, input logic [7:0] d, input logic [8:0] e);
    wr(a, d);
    settle;
    chk({7'h00, serial_clock_pin_oe, serial_data_pin_oe}, e);
  endtask
  task summarize;
    $display("errors %0d checks %0d", num_errors, samples_checked);
    if (num_errors == 0 && samples_checked > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task wait_hi(input int w);
    int i;
    for (i = 0; i < 3000; i++) begin
      @(posedge mclk);
      #1;
      if (w == 0 && irq === 1'b1 || w == 1 && wake === 1'b1 || w == 2 && pr.cnt === 4'h9)
        return;
    end
    num_errors++;
    summarize();
  endtask
  initial begin
    repeat (8) @(posedge mclk);
    reset <= 1'b0;
    // both empty flags read as set once reset is over
    rdchk(`SST_OFS_TXCTL, 8'h06);
    rdchk(`SST_OFS_STATUS, 8'h00);
    rdchk(4'hF, 8'h00);
    // high divisor byte must not count while wide baud is off
    wr(`SST_OFS_BAUDL, 8'h03);
    wr(`SST_OFS_BAUDH, 8'h01);
    wr(`SST_OFS_RXCTL, 8'h80);
    wr(`SST_OFS_TXCTL, 8'hB0);
    wr(`SST_OFS_MASK, 8'h02);
    wr(`SST_OFS_SYSCTL, 8'h03);
    pr.cnt = 4'h0;
    wr(`SST_OFS_HOLD, 8'hA5);
    wait_hi(0);
    settle;
    chk({7'h00, wake, vector_req}, 9'h001);
    chk({1'b0, pr.rx[8:1]}, 9'h0A5);
    rdchk(`SST_OFS_STATUS, 8'h03);
    settle;
    chk({8'h00, irq}, 9'h000);
    wr(`SST_OFS_MASK, 8'h00);
    wr(`SST_OFS_TXCTL, 8'hF1);
    pr.cnt = 4'h0;
    wr(`SST_OFS_HOLD, 8'h3C);
    wait_hi(2);
    chk(pr.rx, 9'h13C);
    chk({8'h00, irq}, 9'h000);
    rdchk(`SST_OFS_STATUS, 8'h03);
    // slave: two words, then sleep
    wr(`SST_OFS_TXCTL, 8'h30);
    wr(`SST_OFS_HOLD, 8'h81);
    wr(`SST_OFS_HOLD, 8'h42);
    rd(`SST_OFS_STATUS);
    wr(`SST_OFS_MASK, 8'h01);
    wr(`SST_OFS_SYSCTL, 8'h07);
    rdchk(`SST_OFS_TXCTL, 8'h30);
    chk({7'h00, wake, irq}, 9'h000);
    pr.cnt = 4'h0;
    pr.frame(8);
    chk({1'b0, pr.rx[8:1]}, 9'h081);
    wait_hi(1);
    settle;
    chk({8'h00, vector_req}, 9'h001);
    rdchk(`SST_OFS_SYSCTL, 8'h03);
    rdchk(`SST_OFS_TXCTL, 8'h32);
    pr.frame(8);
    chk({1'b0, pr.rx[8:1]}, 9'h042);
    settle;
    rd(`SST_OFS_STATUS);
    wr(`SST_OFS_TXCTL, 8'h10);
    wr(`SST_OFS_HOLD, 8'h55);
    pr.frame(8);
    rdchk(`SST_OFS_STATUS, 8'h00);
    oechk(`SST_OFS_RXCTL, 8'h90, 9'h000);
    oechk(`SST_OFS_RXCTL, 8'hA0, 9'h000);
    oechk(`SST_OFS_RXCTL, 8'h80, 9'h001);
    oechk(`SST_OFS_TXCTL, 8'h90, 9'h003);
    oechk(`SST_OFS_RXCTL, 8'h00, 9'h000);
    wr(`SST_OFS_RXCTL, 8'h80);
    oechk(`SST_OFS_TXCTL, 8'h80, 9'h000);
    summarize();
  end
endmodule
bind sst_transmit sst_transmit_assertions chk_i (.mclk, .reset, .reg_addr, .reg_rd, .reg_wr, .reg_rdata,
  .serial_data_pin_oe, .serial_clock_pin_out, .serial_clock_pin_oe, .irq, .wake, .vector_req);
`default_nettype wire
